// File: rtl/issp_map.svh
// Functional notes
// - Clock idles high; device launches on falling edges, samples on rising edges.
// - Most significant output bit appears when chip select falls, before any clock edge.
// - Each later output bit shifts out after a falling clock edge.
// - Output released to high impedance while chip select is high.
// - A frame is exactly 16 clocks, 16 bits each way, full duplex.
// - Write frame: 1, 0, six-bit address, eight data bits.
// - Read frame: 0, 0, six-bit address, eight ignored bits; data returned next frame.
// - With chip select high, clock and data input are ignored.
`ifndef ISSP_MAP_SVH
`define ISSP_MAP_SVH

`define ISSP_CLK_NS          50
`define ISSP_FAST_MAX        8'h09
`define ISSP_FRAME_BITS      5'h10
`define ISSP_LAST_BIT        5'h0F
`define ISSP_CNT_SAT         12'hFFF
`define ISSP_PERIOD_FAST_US  40
`define ISSP_PERIOD_NORM_US  160
`define ISSP_STALL_FAST_US   9
`define ISSP_STALL_NORM_US   75
`define ISSP_US2CYC(u)       (((u) * 1000 + `ISSP_CLK_NS - 1) / `ISSP_CLK_NS)
`define ISSP_PERIOD_FAST_CYC 12'(`ISSP_US2CYC(`ISSP_PERIOD_FAST_US))
`define ISSP_PERIOD_NORM_CYC 12'(`ISSP_US2CYC(`ISSP_PERIOD_NORM_US))
`define ISSP_STALL_FAST_CYC  12'(`ISSP_US2CYC(`ISSP_STALL_FAST_US))
`define ISSP_STALL_NORM_CYC  12'(`ISSP_US2CYC(`ISSP_STALL_NORM_US))
`define ISSP_CMD_WRITE       2'h2
`define ISSP_CMD_READ        2'h0

`endif

// File: rtl/issp_pkg.sv
package issp_pkg;

   typedef enum logic [1:0] {
      ISSP_IDLE  = 2'b01,
      ISSP_SHIFT = 2'b10
   } issp_state_t;

   typedef struct packed {
      logic        cs_s1;
      logic        cs_s2;
      logic        cs_s3;
      logic        sclk_s1;
      logic        sclk_s2;
      logic        sclk_s3;
      logic        din_s1;
      logic        din_s2;
      issp_state_t state;
      logic [4:0]  bitcnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [15:0] txnext;
      logic        dout;
      logic        oe;
      logic        wr_stb;
      logic [5:0]  wr_addr;
      logic [7:0]  wr_data;
      logic        rd_req;
      logic [5:0]  rd_addr;
      logic        rd_pend;
      logic        fast;
      logic        seen;
      logic [11:0] since_start;
      logic [11:0] since_rise;
      logic        rate_err;
      logic        stall_err;
   } issp_regs_t;

endpackage

// File: rtl/issp_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "issp_map.svh"

module issp_spi_slave (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [7:0]  sample_period_setting_in,
   input  wire logic        cs_n_in,
   input  wire logic        sclk_in,
   input  wire logic        din_in,
   input  wire logic [15:0] rd_data_in,
   output logic             dout_out,
   output logic             dout_oe_out,
   output logic             wr_stb_out,
   output logic [5:0]       wr_addr_out,
   output logic [7:0]       wr_data_out,
   output logic             rd_req_out,
   output logic [5:0]       rd_addr_out,
   output logic             fast_mode_out,
   output logic             rate_err_out,
   output logic             stall_err_out
);

   // ==========================================================
   // state
   // ==========================================================
   localparam issp_pkg::issp_regs_t RST = '{
      cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
      sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_s3: 1'b1,
      state: issp_pkg::ISSP_IDLE,
      since_start: `ISSP_CNT_SAT, since_rise: `ISSP_CNT_SAT,
      default: '0
   };

   issp_pkg::issp_regs_t s_q;
   issp_pkg::issp_regs_t s_d;

   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_fall;
   logic        sclk_rise;
   logic        dec;
   logic [15:0] word;
   logic [11:0] period_lim;
   logic [11:0] stall_lim;

   // edges taken from second and third stages only
   assign cs_fall   = s_q.cs_s3 & ~s_q.cs_s2;
   assign cs_rise   = ~s_q.cs_s3 & s_q.cs_s2;
   assign sclk_fall = s_q.sclk_s3 & ~s_q.sclk_s2;
   assign sclk_rise = ~s_q.sclk_s3 & s_q.sclk_s2;
   assign word      = {s_q.rx[14:0], s_q.din_s2};
   // decode only where the shift branch runs, so strobes and checks agree
   assign dec       = (s_q.state == issp_pkg::ISSP_SHIFT) && !cs_rise && sclk_rise
                      && (s_q.bitcnt == `ISSP_LAST_BIT);
   assign period_lim = s_q.fast ? `ISSP_PERIOD_FAST_CYC : `ISSP_PERIOD_NORM_CYC;
   assign stall_lim  = s_q.fast ? `ISSP_STALL_FAST_CYC : `ISSP_STALL_NORM_CYC;

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      s_d           = s_q;
      s_d.cs_s1     = cs_n_in;
      s_d.cs_s2     = s_q.cs_s1;
      s_d.cs_s3     = s_q.cs_s2;
      s_d.sclk_s1   = sclk_in;
      s_d.sclk_s2   = s_q.sclk_s1;
      s_d.sclk_s3   = s_q.sclk_s2;
      s_d.din_s1    = din_in;
      s_d.din_s2    = s_q.din_s1;
      s_d.fast      = (sample_period_setting_in <= `ISSP_FAST_MAX);
      s_d.wr_stb    = 1'b0;
      s_d.rd_req    = 1'b0;
      s_d.rd_pend   = s_q.rd_req;
      s_d.rate_err  = 1'b0;
      s_d.stall_err = 1'b0;
      if (s_q.since_start != `ISSP_CNT_SAT) begin
         s_d.since_start = s_q.since_start + 12'h001;
      end
      if (s_q.since_rise != `ISSP_CNT_SAT) begin
         s_d.since_rise = s_q.since_rise + 12'h001;
      end
      if (s_q.rd_pend) begin
         s_d.txnext = rd_data_in;
      end
      unique case (s_q.state)
         issp_pkg::ISSP_IDLE: begin
            // clock and data input have no effect here
            s_d.oe = 1'b0;
            if (cs_fall) begin
               s_d.state       = issp_pkg::ISSP_SHIFT;
               s_d.bitcnt      = 5'h00;
               s_d.tx          = s_q.txnext;
               s_d.txnext      = 16'h0000;
               s_d.dout        = s_q.txnext[15];
               s_d.oe          = 1'b1;
               s_d.since_start = 12'h000;
               s_d.rate_err    = s_q.seen && (s_q.since_start < period_lim);
               s_d.stall_err   = s_q.seen && (s_q.since_rise < stall_lim);
            end
         end
         issp_pkg::ISSP_SHIFT: begin
            if (cs_rise) begin
               s_d.state      = issp_pkg::ISSP_IDLE;
               s_d.oe         = 1'b0;
               s_d.since_rise = 12'h000;
               s_d.seen       = 1'b1;
            end else begin
               // first falling edge keeps the msb; later ones advance
               if (sclk_fall && (s_q.bitcnt != 5'h00) && (s_q.bitcnt != `ISSP_FRAME_BITS)) begin
                  s_d.tx   = {s_q.tx[14:0], 1'b0};
                  s_d.dout = s_q.tx[14];
               end
               if (sclk_rise && (s_q.bitcnt != `ISSP_FRAME_BITS)) begin
                  s_d.rx     = word;
                  s_d.bitcnt = s_q.bitcnt + 5'h01;
               end
               if (dec) begin
                  if (word[15:14] == `ISSP_CMD_WRITE) begin
                     s_d.wr_stb  = 1'b1;
                     s_d.wr_addr = word[13:8];
                     s_d.wr_data = word[7:0];
                  end else if (word[15:14] == `ISSP_CMD_READ) begin
                     s_d.rd_req  = 1'b1;
                     s_d.rd_addr = word[13:8];
                  end
               end
            end
         end
         default: begin
            s_d = RST;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign dout_out      = s_q.dout;
   assign dout_oe_out   = s_q.oe;
   assign wr_stb_out    = s_q.wr_stb;
   assign wr_addr_out   = s_q.wr_addr;
   assign wr_data_out   = s_q.wr_data;
   assign rd_req_out    = s_q.rd_req;
   assign rd_addr_out   = s_q.rd_addr;
   assign fast_mode_out = s_q.fast;
   assign rate_err_out  = s_q.rate_err;
   assign stall_err_out = s_q.stall_err;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   property p_msb_at_cs;
      (s_q.state == issp_pkg::ISSP_IDLE) && cs_fall |=> s_q.oe && (s_q.dout == $past(s_q.txnext[15]));
   endproperty
   a_msb_at_cs: assert property (p_msb_at_cs) else $error("msb not driven at select");

   property p_shift_fall;
      (s_q.state == issp_pkg::ISSP_SHIFT) && !cs_rise && sclk_fall && (s_q.bitcnt inside {[5'h01:5'h0F]})
         |=> s_q.dout == $past(s_q.tx[14]);
   endproperty
   a_shift_fall: assert property (p_shift_fall) else $error("output bit not advanced");

   property p_release;
      (s_q.state == issp_pkg::ISSP_SHIFT) && cs_rise |=> !s_q.oe ##1 (!s_q.oe || s_q.state == issp_pkg::ISSP_SHIFT);
   endproperty
   a_release: assert property (p_release) else $error("output not released");

   property p_drive_in_frame;
      (s_q.state == issp_pkg::ISSP_SHIFT) |-> s_q.oe;
   endproperty
   a_drive_in_frame: assert property (p_drive_in_frame) else $error("output idle inside frame");

   property p_ignore_idle;
      (s_q.state == issp_pkg::ISSP_IDLE) && !cs_fall |=> $stable(s_q.rx) && $stable(s_q.bitcnt) && !s_q.wr_stb;
   endproperty
   a_ignore_idle: assert property (p_ignore_idle) else $error("activity taken while deselected");

   property p_strobe_count;
      (s_q.wr_stb || s_q.rd_req) |-> (s_q.bitcnt == `ISSP_FRAME_BITS) && ($past(s_q.bitcnt) == `ISSP_LAST_BIT);
   endproperty
   a_strobe_count: assert property (p_strobe_count) else $error("decode without sixteen bits");

   property p_write;
      dec && (word[15:14] == `ISSP_CMD_WRITE)
         |=> s_q.wr_stb && (s_q.wr_addr == $past(word[13:8])) && (s_q.wr_data == $past(word[7:0]));
   endproperty
   a_write: assert property (p_write) else $error("write frame not decoded");

   property p_read;
      dec && (word[15:14] == `ISSP_CMD_READ) |=> s_q.rd_req && (s_q.rd_addr == $past(word[13:8]))
         ##1 !s_q.rd_req ##1 (s_q.txnext == $past(rd_data_in) || s_q.state == issp_pkg::ISSP_SHIFT);
   endproperty
   a_read: assert property (p_read) else $error("read frame not decoded");

   property p_rate;
      (s_q.state == issp_pkg::ISSP_IDLE) && cs_fall |=>
         (s_q.rate_err == ($past(s_q.seen) && ($past(s_q.since_start) < $past(period_lim))))
         && (s_q.stall_err == ($past(s_q.seen) && ($past(s_q.since_rise) < $past(stall_lim))));
   endproperty
   a_rate: assert property (p_rate) else $error("frame spacing check wrong");

   c_write: cover property (s_q.wr_stb);
   c_read: cover property (s_q.rd_req ##[1:1000] cs_fall);
   c_rate_err: cover property (s_q.rate_err);
   c_stall_err: cover property (s_q.stall_err && s_q.fast);

endmodule

`default_nettype wire

// File: tb/issp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// host master, clock idles high
module issp_host_model (
   input  wire logic clk_in,
   input  wire logic dout_in,
   input  wire logic dout_oe_in,
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      din_out
);
   logic        line;
   logic        last = 1'b0;
   logic        msb;
   logic [15:0] rx;

   // released line shows inverse of last driven bit
   assign line = dout_oe_in ? dout_in : ~last;

   always @(posedge clk_in) begin
      if (dout_oe_in) last <= dout_in;
   end

   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b1;
      din_out  = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // nclk clocks of hc system cycles per half period
   task automatic xfer(input logic [15:0] w, input int nclk, input int hc);
      cs_n_out <= 1'b0;
      wt(hc - 1);
      msb = line;
      wt(1);
      for (int i = 15; i > 15 - nclk; i--) begin
         sclk_out <= 1'b0;
         din_out  <= w[i];
         wt(hc);
         sclk_out <= 1'b1;
         wt(2);
         rx[i] = line;
         wt(hc - 2);
      end
      cs_n_out <= 1'b1;
      din_out  <= ~din_out;
   endtask

   // activity with chip select high
   task automatic noise(input int hc);
      for (int i = 0; i < 16; i++) begin
         sclk_out <= ~sclk_out;
         din_out  <= ~din_out;
         wt(hc);
      end
   endtask
endmodule

`default_nettype wire

// File: tb/issp_spi_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// bench
module issp_spi_slave_tb;
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic [7:0]  setting = 8'h09;
   logic [15:0] rd_data = 16'h0000;
   logic        cs_n, sclk, din, dout, oe, wr_stb, rd_req, fast, rate_err, stall_err;
   logic [5:0]  wr_addr, rd_addr;
   logic [7:0]  wr_data;
   int          failures = 0;
   int          cmp_count = 0;
   int          n_wr, n_rd, n_rate, n_stall;

   always #25 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      rd_data <= {rd_addr, 2'h3, rd_addr, 2'h1};
      if (wr_stb === 1'b1) n_wr++;
      if (rd_req === 1'b1) n_rd++;
      if (rate_err === 1'b1) n_rate++;
      if (stall_err === 1'b1) n_stall++;
   end

   issp_host_model host (.clk_in(clk_in), .dout_in(dout), .dout_oe_in(oe), .cs_n_out(cs_n),
      .sclk_out(sclk), .din_out(din));

   issp_spi_slave dut (.clk_in(clk_in), .srst_in(srst_in), .sample_period_setting_in(setting),
      .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .rd_data_in(rd_data), .dout_out(dout),
      .dout_oe_out(oe), .wr_stb_out(wr_stb), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
      .rd_req_out(rd_req), .rd_addr_out(rd_addr), .fast_mode_out(fast), .rate_err_out(rate_err),
      .stall_err_out(stall_err));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic clr;
      n_wr = 0;
      n_rd = 0;
      n_rate = 0;
      n_stall = 0;
   endtask

   task automatic test_done;
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic t_write;
      clr;
      host.xfer(16'hAAC5, 16, 10);
      wt(6);
      chk("wr_cnt", 16'h0001, 16'(n_wr));
      chk("rd_cnt", 16'h0000, 16'(n_rd));
      chk("wr_addr", 16'h002A, 16'(wr_addr));
      chk("wr_data", 16'h00C5, 16'(wr_data));
      chk("oe_idle", 16'h0000, 16'(oe));
   endtask

   task automatic t_read;
      clr;
      host.xfer(16'h1500, 16, 10);
      wt(50);
      chk("rx_after_wr", 16'h0000, host.rx);
      host.xfer(16'h3F00, 16, 10);
      wt(50);
      chk("rx_rd1", {6'h15, 2'h3, 6'h15, 2'h1}, host.rx);
      host.xfer(16'h8001, 16, 10);
      wt(6);
      chk("msb", 16'h0001, 16'(host.msb));
      chk("rx_rd2", 16'hFFFD, host.rx);
      chk("rd_cnt", 16'h0002, 16'(n_rd));
      chk("rd_addr", 16'h003F, 16'(rd_addr));
   endtask

   task automatic t_refuse;
      clr;
      host.noise(10);
      host.xfer(16'hAAC5, 8, 10);
      wt(50);
      host.xfer(16'h45AA, 16, 10);
      wt(50);
      host.xfer(16'hC5AA, 16, 10);
      wt(6);
      chk("wr_cnt", 16'h0000, 16'(n_wr));
      chk("rd_cnt", 16'h0000, 16'(n_rd));
   endtask

   task automatic t_space(input logic [7:0] s, input int hc, input int gap, input logic er, input logic es);
      setting <= s;
      wt(2);
      chk("fast", 16'(s <= 8'h09), 16'(fast));
      host.xfer(16'h0000, 16, hc);
      wt(gap);
      clr;
      host.xfer(16'h0000, 16, hc);
      wt(6);
      chk("rate_err", 16'(er), 16'(n_rate));
      chk("stall_err", 16'(es), 16'(n_stall));
   endtask

   initial begin
      wt(2);
      srst_in <= 1'b0;
      wt(1);
      chk("oe_reset", 16'h0000, 16'(oe));
      t_write;
      t_read;
      t_refuse;
      t_space(8'h09, 10, 10, 1'b1, 1'b1);
      t_space(8'h09, 10, 200, 1'b1, 1'b0);
      t_space(8'h09, 10, 700, 1'b0, 1'b0);
      t_space(8'h0A, 40, 1000, 1'b1, 1'b1);
      t_space(8'h0A, 40, 2000, 1'b0, 1'b0);
      test_done;
   end

   initial begin
      wt(60000);
      failures++;
      $display("unexpected timeout: expected end seen none");
      test_done;
   end
endmodule

`default_nettype wire
